// ---- bench/gocr_host_model.sv ----
/*
 * Host side of the byte management port: issues single-byte accesses, notes
 * the expected read byte in a queue and compares it when the ack arrives.
 * Assumes requests change on the falling clock edge and ack one cycle later.
 */
module gocr_host_model (
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    output gocr_pkg::gocr_req_t host_req,
    input  wire logic [7:0]     host_rdata,
    input  wire logic           host_ack,
    output int                  mis_cnt,
    output int                  chk_cnt,
    output logic                hang
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] exp_q[$];
    int         wait_n;

    initial begin
        host_req = '0;
        mis_cnt  = 0;
        chk_cnt  = 0;
        hang     = 1'b0;
        wait_n   = 0;
    end

    // writes are only ever aimed at mapped space by the callers
    task automatic access(input logic we, input logic [15:0] addr, input logic [7:0] wd,
                          input logic [7:0] exp);
        @(negedge ref_clk);
        host_req <= '{req: 1'b1, we: we, addr: addr, wdata: wd};
        exp_q.push_back(we ? 8'h00 : exp);
    endtask

    // a released bus shows the inverse, so stale values cannot pass
    task automatic release_bus();
        @(negedge ref_clk);
        host_req <= '{req: 1'b0, we: ~host_req.we, addr: ~host_req.addr,
                      wdata: ~host_req.wdata};
    endtask

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wait_n <= 0;
        end else if (host_ack === 1'b1) begin
            chk_cnt <= chk_cnt + 1;
            wait_n  <= 0;
            if (exp_q.size() == 0) begin
                mis_cnt <= mis_cnt + 1;
                $display("unexpected host_ack expected 0 seen 1");
            end else begin
                if (host_rdata !== exp_q[0]) begin
                    mis_cnt <= mis_cnt + 1;
                    $display("unexpected host_rdata expected %h seen %h", exp_q[0], host_rdata);
                end
                exp_q.delete(0);
            end
        end else if (exp_q.size() != 0) begin
            wait_n <= wait_n + 1;
            if (wait_n > 2) begin
                hang <= 1'b1;
            end
        end
    end
endmodule

// ---- bench/gocr_regs_bench.sv ----
/*
 * Self-checking bench for the global operation control register bank.
 * Assumes the host model for all register traffic; pins are driven here.
 */
module gocr_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] ID_A = 8'h3E;  // arbitrary value
    localparam logic [7:0] ID_B = 8'hC4;  // arbitrary value
    localparam logic [7:0] ID_C = 8'h19;  // arbitrary value
    localparam logic [3:0] REV  = 4'h6;   // arbitrary value

    logic                ref_clk, sys_rst, lue_irq_in, tstrig_irq_in, pme_event;
    logic [6:0]          port_irq_in, m;
    gocr_pkg::gocr_req_t host_req, ext_req;
    gocr_pkg::gocr_dec_t ext_dec;
    gocr_pkg::gocr_grp_t eg;
    logic [7:0]          host_rdata, rnd;
    logic                host_ack, pme_pin_o, pme_pin_oe, host_irq, datapath_rst, hang;
    int                  mis_cnt, chk_cnt, bad_count, check_count, n, i;
    logic [15:0]         dec_a[10] = '{16'h0010, 16'h0100, 16'h0500, 16'h3C00, 16'h7BFF,
                                       16'h0600, 16'h0FFF, 16'h1700, 16'h1D00, 16'h8000};

    gocr_regs #(.ID_FIXED(ID_A), .ID_HIGH(ID_B), .ID_LOW(ID_C), .REV_ID(REV), .NPORTS(7)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .host_req(host_req), .host_rdata(host_rdata),
        .host_ack(host_ack), .ext_req(ext_req), .ext_dec(ext_dec), .lue_irq_in(lue_irq_in),
        .tstrig_irq_in(tstrig_irq_in), .port_irq_in(port_irq_in), .pme_event(pme_event),
        .pme_pin_o(pme_pin_o), .pme_pin_oe(pme_pin_oe), .host_irq(host_irq),
        .datapath_rst(datapath_rst));

    gocr_host_model host (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .host_req(host_req), .host_rdata(host_rdata),
        .host_ack(host_ack), .mis_cnt(mis_cnt), .chk_cnt(chk_cnt), .hang(hang));

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count + chk_cnt, bad_count + mis_cnt);
        if (bad_count + mis_cnt == 0 && check_count + chk_cnt > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic settle(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00, exp);
        host.release_bus();
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, 8'h00);
        host.release_bus();
    endtask

    // read first, or in the wanted bits, write back
    task automatic rmw(input logic [15:0] a, input logic [7:0] cur, input logic [7:0] set);
        rd(a, cur);
        wr(a, cur | set);
    endtask

    task automatic srst(input logic [7:0] d, input int exp_n);
        n = 0;
        fork
            begin
                wr(16'h0003, d);
                rd(16'h0003, {REV, 3'h0, d[0]});
            end
            repeat (45) begin
                @(negedge ref_clk);
                n += (datapath_rst === 1'b1);
            end
        join
        chk("datapath_rst cycles", exp_n[7:0], n[7:0]);
        rd(16'h0003, {REV, 4'h0});
    endtask

    // s 0 lookup engine, 1 trigger and timestamp, 2 to 8 ports 1 to 7
    task automatic irq_src(input int s);
        logic [15:0] sa;
        logic [15:0] ma;
        logic [7:0]  bv;
        sa = (s < 2) ? 16'h0010 : 16'h001B;
        ma = (s < 2) ? 16'h0014 : 16'h001F;
        bv = (s < 2) ? (8'h80 >> s) : (8'h01 << (s - 2));
        lue_irq_in    = (s == 0);
        tstrig_irq_in = (s == 1);
        port_irq_in   = (s < 2) ? 7'h00 : bv[6:0];
        settle(3);
        chk("host_irq", 8'h01, {7'h00, host_irq});
        rd(sa, bv);
        wr(ma, bv);
        settle(3);
        chk("host_irq masked", 8'h00, {7'h00, host_irq});
        rd(ma, bv);
        wr(ma, 8'h00);
        lue_irq_in    = 1'b0;
        tstrig_irq_in = 1'b0;
        port_irq_in   = 7'h00;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        close_out();
    end

    always @(posedge ref_clk) begin
        if (hang === 1'b1) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        sys_rst       = 1'b1;
        lue_irq_in    = 1'b0;
        tstrig_irq_in = 1'b0;
        port_irq_in   = 7'h00;
        pme_event     = 1'b0;
        bad_count     = 0;
        check_count   = 0;
        rnd           = 8'h2C;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        chk("pme_pin_oe reset", 8'h00, {7'h00, pme_pin_oe});
        chk("host_irq reset", 8'h00, {7'h00, host_irq});
        // back-to-back identification reads
        host.access(1'b0, 16'h0000, 8'h00, ID_A);
        host.access(1'b0, 16'h0001, 8'h00, ID_B);
        host.access(1'b0, 16'h0002, 8'h00, ID_C);
        host.access(1'b0, 16'h0003, 8'h00, {REV, 4'h0});
        host.release_bus();
        rd(16'h0006, 8'h00);
        for (i = 0; i < 16; i++) rd(16'h0010 + i[15:0], 8'h00);
        for (i = 0; i < 3; i++) begin
            rnd = lfsr_next(rnd);
            wr(i[15:0], rnd);
        end
        rd(16'h0000, ID_A);
        rd(16'h0001, ID_B);
        rd(16'h0002, ID_C);
        wr(16'h0003, 8'hF0);
        rd(16'h0003, {REV, 4'h0});
        wr(16'h0010, 8'hFF);
        rd(16'h0010, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(16'h0006, 8'h00);
            rmw(16'h0006, 8'h00, {6'h00, 1'b1, i[0]});
            settle(2);
            chk("pme_pin_oe", 8'h01, {7'h00, pme_pin_oe});
            repeat (2) begin
                pme_event = ~pme_event;
                settle(2);
                chk("pme_pin_o", {7'h00, i[0] ? pme_event : ~pme_event}, {7'h00, pme_pin_o});
            end
        end
        wr(16'h0006, 8'h01);
        settle(3);
        chk("pme_pin_oe off", 8'h00, {7'h00, pme_pin_oe});
        wr(16'h0006, 8'h03);
        srst(8'h01, gocr_pkg::SRST_CYCLES);
        srst(8'h00, 0);
        rd(16'h0006, 8'h03);
        for (i = 0; i < 9; i++) irq_src(i);
        for (i = 0; i < 6; i++) begin
            rnd = lfsr_next(rnd);
            m   = rnd[6:0];
            wr(16'h001F, {1'b0, m});
            rnd         = lfsr_next(rnd);
            port_irq_in = rnd[6:0];
            settle(3);
            chk("host_irq random", {7'h00, |(rnd[6:0] & ~m)}, {7'h00, host_irq});
        end
        port_irq_in = 7'h00;
        wr(16'h001F, 8'h00);
        for (i = 0; i < 10; i++) begin
            eg = (i == 0) ? gocr_pkg::GOCR_GRP_OPCTRL :
                 (i < 5) ? gocr_pkg::GOCR_GRP_OTHER : gocr_pkg::GOCR_GRP_RSVD;
            host.access(1'b0, dec_a[i], 8'h00, 8'h00);
            host.release_bus();
            chk("ext_dec grp", {6'h00, eg}, {6'h00, ext_dec.grp});
            chk("ext_req req", {7'h00, eg == gocr_pkg::GOCR_GRP_OTHER}, {7'h00, ext_req.req});
            if (i < 5) begin
                chk("ext_dec port page", dec_a[i][15:8], {ext_dec.port, ext_dec.page});
            end
            if (eg == gocr_pkg::GOCR_GRP_OTHER) begin
                chk("ext_req addr", dec_a[i][7:0], ext_req.addr[7:0]);
            end
        end
        settle(4);
        close_out();
    end
endmodule

// ---- rtl/gocr_addr_decode.sv ----
/*
 * Combinational decode of a 16-bit register address into port, page and
 * group: this bank, another functional group, or reserved space.
 * Assumes the caller registers the result.
 */
module gocr_addr_decode (
    input  wire logic [15:0]         addr,
    output gocr_pkg::gocr_dec_t      dec
);

    logic [3:0] port;
    logic [3:0] page;

    assign port = addr[15:12];
    assign page = addr[11:8];

    always_comb begin
        dec.port = port;
        dec.page = page;
        dec.grp  = gocr_pkg::GOCR_GRP_RSVD;
        // port nibble, page nibble, register byte; bit 15 set decodes as reserved
        if (port == 4'h0) begin
            // six global groups, rest up to 4 KB reserved
            if (page == 4'h0) begin
                dec.grp = gocr_pkg::GOCR_GRP_OPCTRL;
            end else if (page <= gocr_pkg::GLB_PAGE_LAST) begin
                dec.grp = gocr_pkg::GOCR_GRP_OTHER;
            end
        end else if (port <= gocr_pkg::PORT_LAST) begin
            // port pages 0..C, page 7 and D..F reserved
            if (page != gocr_pkg::PORT_PAGE_RSVD && page <= gocr_pkg::PORT_PAGE_LAST) begin
                dec.grp = gocr_pkg::GOCR_GRP_OTHER;
            end
        end
    end

endmodule

// ---- rtl/gocr_pkg.sv ----
/*
 * Shared constants and types for the global operation control register bank:
 * byte offsets, field positions, reset values, soft-reset timing and the
 * packed carriers for host byte accesses and address decode.
 * Assumes a byte-wide host management port, 16-bit addresses, 250 MHz clock.
 */
package gocr_pkg;

    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 8;
    localparam int NUM_PORTS    = 7;

    // byte offsets inside the operation control page
    localparam logic [7:0] OFF_ID_FIXED   = 8'h00;
    localparam logic [7:0] OFF_ID_HIGH    = 8'h01;
    localparam logic [7:0] OFF_ID_LOW     = 8'h02;
    localparam logic [7:0] OFF_REV_SRST   = 8'h03;
    localparam logic [7:0] OFF_PME_CTRL   = 8'h06;
    localparam logic [7:0] OFF_GIRQ_STAT  = 8'h10;
    localparam logic [7:0] OFF_GIRQ_MASK  = 8'h14;
    localparam logic [7:0] OFF_PIRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_PIRQ_MASK  = 8'h1C;

    // field positions
    localparam int SRST_BIT     = 0;
    localparam int REV_LSB      = 4;
    localparam int PME_OE_BIT   = 1;
    localparam int PME_POL_BIT  = 0;
    localparam int LUE_BIT      = 31;
    localparam int TSTRIG_BIT   = 30;

    // reset values
    localparam logic       PME_OE_RST  = 1'b0;
    localparam logic       PME_POL_RST = 1'b0;
    localparam logic [1:0] GMASK_RST   = 2'h0;
    localparam logic [6:0] PMASK_RST   = 7'h00;

    // address map pages
    localparam logic [3:0] GLB_PAGE_LAST  = 4'h5;
    localparam logic [3:0] PORT_PAGE_RSVD = 4'h7;
    localparam logic [3:0] PORT_PAGE_LAST = 4'hC;
    localparam logic [3:0] PORT_LAST      = 4'h7;

    // datapath reset pulse length
    localparam int CLK_MHZ       = 250;
    localparam int SRST_TIME_NS  = 100;
    localparam int SRST_CYCLES   = (SRST_TIME_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        GOCR_GRP_OPCTRL,
        GOCR_GRP_OTHER,
        GOCR_GRP_RSVD
    } gocr_grp_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } gocr_req_t;

    typedef struct packed {
        logic [3:0] port;
        logic [3:0] page;
        gocr_grp_t  grp;
    } gocr_dec_t;

endpackage

// ---- rtl/gocr_regs.sv ----
/*
 * Global operation control register bank: address decode for the whole
 * register space, identification bytes, self-clearing datapath reset,
 * power-event pin control and two-level interrupt summary with masks.
 * Assumes one byte access per request from the host management port and
 * level interrupt requests from the lookup engine, timestamp unit and ports.
 */
// How it works
// - global space split in 256-byte groups; above PTP group reserved to 4 KB.
// - ports 1-7 use pages 0 to C; page 7 and D-F reserved.
// - first three bytes are fixed read-only identification; writes ignored.
// - fourth byte holds revision in upper nibble, reserved, reset bit 0.
// - writing 1 resets datapath, keeps registers, bit clears when done.
// - power-event pin driven only while enable bit 1 is set; resets 0.
// - polarity bit 0 picks active level, 0 low, 1 high; resets 0.
// - global status shows lookup engine and trigger/timestamp request flags.
// - lookup engine flag at bit 31, read-only, reset 0.
// - trigger and timestamp flag at bit 30, read-only, reset 0.
// - global mask bits 31 and 30; 0 enables, 1 disables; reset 0.
// - port status flag n at bit n-1, bits 31-7 read zero.
// - port mask bit per port; 0 enables, 1 disables.
// - 16-bit address: port nibble, page nibble, register byte; bit 15 zero.
// - byte access in any order; multi-byte registers big-endian.
module gocr_regs #(
    parameter logic [7:0] ID_FIXED  = 8'h5A,  // arbitrary value
    parameter logic [7:0] ID_HIGH   = 8'hA1,  // arbitrary value
    parameter logic [7:0] ID_LOW    = 8'h3C,  // arbitrary value
    parameter logic [3:0] REV_ID    = 4'h2,   // arbitrary value
    parameter int         NPORTS    = gocr_pkg::NUM_PORTS
) (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  gocr_pkg::gocr_req_t        host_req,
    output logic [7:0]                 host_rdata,
    output logic                       host_ack,
    output gocr_pkg::gocr_req_t        ext_req,
    output gocr_pkg::gocr_dec_t        ext_dec,
    input  wire logic                  lue_irq_in,
    input  wire logic                  tstrig_irq_in,
    input  wire logic [NPORTS-1:0]     port_irq_in,
    input  wire logic                  pme_event,
    output logic                       pme_pin_o,
    output logic                       pme_pin_oe,
    output logic                       host_irq,
    output logic                       datapath_rst
);

    localparam int SRST_CW   = $clog2(gocr_pkg::SRST_CYCLES + 1);
    localparam int SRST_WAIT = gocr_pkg::SRST_CYCLES + 2;

    gocr_pkg::gocr_dec_t dec;
    logic                hit;
    logic                wr;
    logic [7:0]          reg_off;

    gocr_addr_decode u_dec (
        .addr (host_req.addr),
        .dec  (dec)
    );

    assign hit     = host_req.req && (dec.grp == gocr_pkg::GOCR_GRP_OPCTRL);
    assign wr      = hit && host_req.we;
    assign reg_off = host_req.addr[7:0];

    // control and status state
    logic                 srst_q,    srst_d;
    logic [SRST_CW-1:0]   srst_cnt_q, srst_cnt_d;
    logic                 pme_oe_q,  pme_oe_d;
    logic                 pme_pol_q, pme_pol_d;
    logic [1:0]           gmask_q,   gmask_d;
    logic [NPORTS-1:0]    pmask_q,   pmask_d;
    logic [1:0]           gstat_q,   gstat_d;
    logic [NPORTS-1:0]    pstat_q,   pstat_d;

    always_comb begin
        srst_d     = srst_q;
        srst_cnt_d = srst_cnt_q;
        pme_oe_d   = pme_oe_q;
        pme_pol_d  = pme_pol_q;
        gmask_d    = gmask_q;
        pmask_d    = pmask_q;
        // flags follow the source request levels
        gstat_d    = {lue_irq_in, tstrig_irq_in};
        pstat_d    = port_irq_in;

        // count down, then bit clears itself
        if (srst_q) begin
            if (srst_cnt_q == SRST_CW'(1)) begin
                srst_d = 1'b0;
            end
            srst_cnt_d = srst_cnt_q - SRST_CW'(1);
        end

        if (wr) begin
            unique case (reg_off)
                gocr_pkg::OFF_REV_SRST: begin
                    // a 1 (re)starts the reset, a 0 changes nothing
                    if (host_req.wdata[gocr_pkg::SRST_BIT]) begin
                        srst_d     = 1'b1;
                        srst_cnt_d = SRST_CW'(gocr_pkg::SRST_CYCLES);
                    end
                end
                gocr_pkg::OFF_PME_CTRL: begin
                    pme_oe_d  = host_req.wdata[gocr_pkg::PME_OE_BIT];
                    pme_pol_d = host_req.wdata[gocr_pkg::PME_POL_BIT];
                end
                gocr_pkg::OFF_GIRQ_MASK: begin
                    // mask bits 31:30 live in the first byte
                    gmask_d = host_req.wdata[7:6];
                end
                gocr_pkg::OFF_PIRQ_MASK + 8'h03: begin
                    // port masks in the least significant byte
                    pmask_d = host_req.wdata[NPORTS-1:0];
                end
                // identification and status bytes ignore writes
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            srst_q     <= 1'b0;
            srst_cnt_q <= '0;
            pme_oe_q   <= gocr_pkg::PME_OE_RST;
            pme_pol_q  <= gocr_pkg::PME_POL_RST;
            gmask_q    <= gocr_pkg::GMASK_RST;
            pmask_q    <= gocr_pkg::PMASK_RST;
            gstat_q    <= 2'h0;
            pstat_q    <= '0;
        end else begin
            srst_q     <= srst_d;
            srst_cnt_q <= srst_cnt_d;
            pme_oe_q   <= pme_oe_d;
            pme_pol_q  <= pme_pol_d;
            gmask_q    <= gmask_d;
            pmask_q    <= pmask_d;
            gstat_q    <= gstat_d;
            pstat_q    <= pstat_d;
        end
    end

    // read data: 32-bit words assembled then byte-picked
    logic [31:0] gstat_w, gmask_w, pstat_w, pmask_w;

    // lookup engine flag at 31; trigger/timestamp at 30
    assign gstat_w = {gstat_q, 30'h0000_0000};
    assign gmask_w = {gmask_q, 30'h0000_0000};
    // port n at bit n-1, upper bits zero
    assign pstat_w = {{(32-NPORTS){1'b0}}, pstat_q};
    assign pmask_w = {{(32-NPORTS){1'b0}}, pmask_q};

    function automatic logic [7:0] pick_be(input logic [31:0] w, input logic [1:0] b);
        logic [7:0] r;
        // lowest address holds the most significant byte
        unique case (b)
            2'h0: r = w[31:24];
            2'h1: r = w[23:16];
            2'h2: r = w[15:8];
            2'h3: r = w[7:0];
        endcase
        return r;
    endfunction

    // bus answer state
    logic [7:0]           rdata_q, rdata_d;
    logic                 ack_q,   ack_d;
    gocr_pkg::gocr_req_t  ext_q,   ext_d;
    gocr_pkg::gocr_dec_t  edec_q,  edec_d;

    always_comb begin
        ack_d   = host_req.req;
        rdata_d = 8'h00;
        ext_d   = host_req;
        edec_d  = dec;
        // reserved space neither forwarded nor stored
        ext_d.req = host_req.req && (dec.grp == gocr_pkg::GOCR_GRP_OTHER);
        if (hit && !host_req.we) begin
            unique case (reg_off[7:2])
                6'h00: begin
                    unique case (reg_off[1:0])
                        2'h0: rdata_d = ID_FIXED;
                        2'h1: rdata_d = ID_HIGH;
                        2'h2: rdata_d = ID_LOW;
                        // revision high nibble, reserved zero, reset bit
                        2'h3: rdata_d = {REV_ID, 3'h0, srst_q};
                    endcase
                end
                6'h01: begin
                    if (reg_off[1:0] == gocr_pkg::OFF_PME_CTRL[1:0]) begin
                        rdata_d = {6'h00, pme_oe_q, pme_pol_q};
                    end
                end
                6'h04:   rdata_d = pick_be(gstat_w, reg_off[1:0]);
                6'h05:   rdata_d = pick_be(gmask_w, reg_off[1:0]);
                6'h06:   rdata_d = pick_be(pstat_w, reg_off[1:0]);
                6'h07:   rdata_d = pick_be(pmask_w, reg_off[1:0]);
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            ack_q   <= 1'b0;
            ext_q   <= '0;
            edec_q  <= '0;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            ext_q   <= ext_d;
            edec_q  <= edec_d;
        end
    end

    // pin and interrupt outputs
    logic pme_o_q, pme_o_d;
    logic pme_oe_out_q;
    logic irq_q, irq_d;
    logic dp_rst_q;

    always_comb begin
        pme_o_d = pme_pol_q ? pme_event : ~pme_event;
        // any unmasked flag raises the request
        irq_d   = |(gstat_q & ~gmask_q) || |(pstat_q & ~pmask_q);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pme_o_q      <= 1'b1;
            pme_oe_out_q <= 1'b0;
            irq_q        <= 1'b0;
            dp_rst_q     <= 1'b0;
        end else begin
            pme_o_q      <= pme_o_d;
            pme_oe_out_q <= pme_oe_q;
            irq_q        <= irq_d;
            dp_rst_q     <= srst_q;
        end
    end

    assign host_rdata   = rdata_q;
    assign host_ack     = ack_q;
    assign ext_req      = ext_q;
    assign ext_dec      = edec_q;
    assign pme_pin_o    = pme_o_q;
    assign pme_pin_oe   = pme_oe_out_q;
    assign host_irq     = irq_q;
    assign datapath_rst = dp_rst_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    ack_one_cycle_a: assert property (
        host_req.req |=> host_ack)
        else $error("request not answered next cycle");

    id_read_only_a: assert property (
        (host_req.req && !host_req.we && host_req.addr == 16'h0001) |=> host_rdata == ID_HIGH)
        else $error("identification byte wrong");

    glb_rsvd_drop_a: assert property (
        (host_req.req && host_req.addr[15:12] == 4'h0 && host_req.addr[11:8] > 4'h5)
        |=> !ext_req.req && host_rdata == 8'h00)
        else $error("reserved global space reached");

    port_page7_a: assert property (
        (host_req.req && host_req.addr[15:12] == 4'h3 && host_req.addr[11:8] == 4'h7)
        |=> !ext_req.req)
        else $error("reserved port page forwarded");

    addr15_rsvd_a: assert property (
        (host_req.req && host_req.addr[15]) |=> !ext_req.req && host_rdata == 8'h00)
        else $error("address with bit 15 set accepted");

    srst_clears_a: assert property (
        $rose(srst_q) |-> ##[1:SRST_WAIT] !srst_q)
        else $error("reset bit did not clear in time");

    srst_pulse_a: assert property (
        $rose(srst_q) |=> datapath_rst [*8])
        else $error("datapath reset too short");

    pme_disable_a: assert property (
        (wr && reg_off == 8'h06 && !host_req.wdata[1]) |=> ##1 !pme_pin_oe)
        else $error("pin driven while disabled");

    pme_level_a: assert property (
        pme_pin_oe |-> pme_pin_o == ($past(pme_pol_q) ? $past(pme_event) : !$past(pme_event)))
        else $error("pin level ignores polarity");

    irq_masked_a: assert property (
        (gmask_q == 2'h3 && pmask_q == '1) [*2] |=> !host_irq)
        else $error("masked flags raised interrupt");

    irq_unmasked_a: assert property (
        (pstat_q[0] && !pmask_q[0]) |=> host_irq)
        else $error("unmasked port flag lost");

    port_flag_read_a: assert property (
        (host_req.req && !host_req.we && host_req.addr == 16'h001B)
        |=> host_rdata == {1'b0, $past(pstat_q)})
        else $error("port status byte wrong");

    srst_seen_c: cover property ($rose(srst_q) ##[1:SRST_WAIT] $fell(srst_q));
    irq_seen_c:  cover property ($rose(host_irq));
    pme_on_c:    cover property ($rose(pme_pin_oe));
    ext_fwd_c:   cover property (ext_req.req && ext_req.we);

endmodule
